// >>> src/sfr_pkg.sv
/*
 * Package for the factory information and fuse row block: register map,
 * field positions, reset values and bus types.
 * Assumes a 32-bit AXI4-Lite register bus and one system clock.
 */
package sfr_pkg;

    // ------------------------------------------------------------
    // Address map
    // ------------------------------------------------------------
    // Row offsets are byte indices; byte address is four times the index
    localparam int unsigned ADDR_W          = 12;
    localparam logic [11:0] SIG_BASE        = 12'h000;
    localparam logic [11:0] FUSE_BASE       = 12'h400;
    localparam logic [11:0] WDT_CTRL_ADDR   = 12'h800;
    localparam int unsigned SIG_BYTES       = 38;
    localparam int unsigned FUSE_BYTES      = 11;

    localparam logic [7:0] IDENTITY_IDX     = 8'h00;
    localparam logic [7:0] UNIQUE_ID_IDX    = 8'h03;
    localparam logic [7:0] UNIQUE_ID_LAST   = 8'h0C;
    localparam logic [7:0] TEMP_GAIN_IDX    = 8'h20;
    localparam logic [7:0] TEMP_OFFSET_IDX  = 8'h21;
    localparam logic [7:0] OSC_LOW_3V_IDX   = 8'h22;
    localparam logic [7:0] OSC_LOW_5V_IDX   = 8'h23;
    localparam logic [7:0] OSC_HIGH_3V_IDX  = 8'h24;
    localparam logic [7:0] OSC_HIGH_5V_IDX  = 8'h25;

    localparam logic [7:0] WDT_FUSE_IDX     = 8'h00;
    localparam logic [7:0] BOD_FUSE_IDX     = 8'h01;
    localparam logic [7:0] OSC_FUSE_IDX     = 8'h02;
    localparam logic [7:0] TIMER_FUSE_IDX   = 8'h04;
    localparam logic [7:0] SYS_A_FUSE_IDX   = 8'h05;
    localparam logic [7:0] SYS_B_FUSE_IDX   = 8'h06;
    localparam logic [7:0] APP_END_FUSE_IDX = 8'h07;
    localparam logic [7:0] BOOT_END_IDX     = 8'h08;
    localparam logic [7:0] LOCK_FUSE_IDX    = 8'h0A;
    localparam logic [7:0] FUSE_RSV_A_IDX   = 8'h03;
    localparam logic [7:0] FUSE_RSV_B_IDX   = 8'h09;

    // ------------------------------------------------------------
    // Fields and reset values
    // ------------------------------------------------------------
    localparam int unsigned WINDOW_MSB      = 7;
    localparam int unsigned WINDOW_LSB      = 4;
    localparam int unsigned PERIOD_MSB      = 3;
    localparam int unsigned PERIOD_LSB      = 0;
    localparam logic [7:0]  WDT_CTRL_RST    = 8'h00;
    localparam logic [1:0]  RESP_OKAY       = 2'h0;
    localparam logic [1:0]  RESP_SLVERR     = 2'h2;
    localparam logic [31:0] DATA_ZERO       = 32'h0000_0000;

    // ------------------------------------------------------------
    // Bus carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic [11:0] addr;
        logic        valid;
    } sfr_addr_t;

    typedef struct packed {
        logic [31:0] data;
        logic [1:0]  resp;
        logic        valid;
    } sfr_rresp_t;

    typedef enum logic [1:0] {
        SFR_RD_IDLE = 2'b01,
        SFR_RD_RESP = 2'b10
    } sfr_rd_state_t;

    typedef enum logic [2:0] {
        SFR_WR_IDLE = 3'b001,
        SFR_WR_HALF = 3'b010,
        SFR_WR_RESP = 3'b100
    } sfr_wr_state_t;

endpackage : sfr_pkg

// >>> src/sfr_rows.sv
/*
 * Factory information row and configuration fuse row, read-only over
 * AXI4-Lite, plus the watchdog first control register loaded from the
 * watchdog fuse during reset.
 * Assumes the nonvolatile contents arrive as stable input vectors and
 * that nrst is synchronous to clock.
 */
`timescale 1ns/100ps
`default_nettype none

// Overview of operation
// RULE1: Three identity bytes at offsets zero to two
// RULE2: Ten serial bytes from offset three
// RULE3: Gain byte then signed offset byte
// RULE4: Signed 16 MHz error at 3 V
// RULE5: Signed 16 MHz error at 5 V
// RULE6: Signed 20 MHz error at 3 V
// RULE7: Signed 20 MHz error at 5 V
// RULE8: Reset copies fuse upper nibble to window
// RULE9: Reset copies fuse lower nibble to period
// RULE10: Fuses read-only, changes apply after reset
// RULE11: Writes ignored, reserved locations read zero
module sfr_rows (
    input  wire logic                  clock,
    input  wire logic                  nrst,
    input  wire logic [23:0]           identity_code,
    input  wire logic [79:0]           unique_id,
    input  wire logic [15:0]           temp_correction,
    input  wire logic [7:0]            osc_low_freq_error_3v,
    input  wire logic [7:0]            osc_low_freq_error_5v,
    input  wire logic [7:0]            osc_high_freq_error_3v,
    input  wire logic [7:0]            osc_high_freq_error_5v,
    input  wire logic [87:0]           fuse_row_nv,
    input  wire logic [sfr_pkg::ADDR_W-1:0] s_axi_awaddr,
    input  wire logic                  s_axi_awvalid,
    output logic                       s_axi_awready,
    input  wire logic [31:0]           s_axi_wdata,
    input  wire logic [3:0]            s_axi_wstrb,
    input  wire logic                  s_axi_wvalid,
    output logic                       s_axi_wready,
    output logic [1:0]                 s_axi_bresp,
    output logic                       s_axi_bvalid,
    input  wire logic                  s_axi_bready,
    input  wire logic [sfr_pkg::ADDR_W-1:0] s_axi_araddr,
    input  wire logic                  s_axi_arvalid,
    output logic                       s_axi_arready,
    output logic [31:0]                s_axi_rdata,
    output logic [1:0]                 s_axi_rresp,
    output logic                       s_axi_rvalid,
    input  wire logic                  s_axi_rready,
    output logic [7:0]                 watchdog_control_first
);
    import sfr_pkg::*;

    // ------------------------------------------------------------
    // Row images
    // ------------------------------------------------------------
    logic [7:0] sig_bytes  [SIG_BYTES];
    logic [7:0] fuse_r     [FUSE_BYTES];
    logic [7:0] wdt_ctrl_r;

    // Signature row is wired straight from the factory store; gaps read zero
    genvar gi;
    generate
        for (gi = 0; gi < SIG_BYTES; gi++) begin : g_sig
            if (gi < UNIQUE_ID_IDX) begin : g_id
                assign sig_bytes[gi] = identity_code[gi*8 +: 8]; // [RULE1]
            end else if (gi <= UNIQUE_ID_LAST) begin : g_ser
                assign sig_bytes[gi] = unique_id[(gi-UNIQUE_ID_IDX)*8 +: 8]; // [RULE2]
            end else if (gi == TEMP_GAIN_IDX || gi == TEMP_OFFSET_IDX) begin : g_tmp
                assign sig_bytes[gi] = temp_correction[(gi-TEMP_GAIN_IDX)*8 +: 8]; // [RULE3]
            end else if (gi == OSC_LOW_3V_IDX) begin : g_o1
                assign sig_bytes[gi] = osc_low_freq_error_3v; // [RULE4]
            end else if (gi == OSC_LOW_5V_IDX) begin : g_o2
                assign sig_bytes[gi] = osc_low_freq_error_5v; // [RULE5]
            end else if (gi == OSC_HIGH_3V_IDX) begin : g_o3
                assign sig_bytes[gi] = osc_high_freq_error_3v; // [RULE6]
            end else if (gi == OSC_HIGH_5V_IDX) begin : g_o4
                assign sig_bytes[gi] = osc_high_freq_error_5v; // [RULE7]
            end else begin : g_rsv
                assign sig_bytes[gi] = 8'h00; // [RULE11]
            end
        end
        // Fuses are latched only in reset so a changed fuse waits for the next one
        for (gi = 0; gi < FUSE_BYTES; gi++) begin : g_fuse
            always_ff @(posedge clock) begin
                if (!nrst) begin
                    fuse_r[gi] <= (gi == FUSE_RSV_A_IDX || gi == FUSE_RSV_B_IDX)
                                  ? 8'h00 : fuse_row_nv[gi*8 +: 8]; // [RULE10] [RULE11]
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // Watchdog control load
    // ------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (!nrst) begin
            wdt_ctrl_r[WINDOW_MSB:WINDOW_LSB] <= fuse_row_nv[WINDOW_MSB:WINDOW_LSB]; // [RULE8]
            wdt_ctrl_r[PERIOD_MSB:PERIOD_LSB] <= fuse_row_nv[PERIOD_MSB:PERIOD_LSB]; // [RULE9]
        end
    end
    assign watchdog_control_first = wdt_ctrl_r;

    // ------------------------------------------------------------
    // Read channel
    // ------------------------------------------------------------
    sfr_rd_state_t rd_state_r;
    sfr_rd_state_t rd_state_nxt;
    sfr_rresp_t    rd_r;
    sfr_rresp_t    rd_nxt;
    wire           ar_take   = s_axi_arvalid && (rd_state_r == SFR_RD_IDLE);
    wire [9:0]     rd_index  = s_axi_araddr[11:2];
    wire           hit_sig   = (s_axi_araddr[11:10] == SIG_BASE[11:10]);
    wire           hit_fuse  = (s_axi_araddr[11:10] == FUSE_BASE[11:10]);
    wire           hit_wdt   = (s_axi_araddr == WDT_CTRL_ADDR);
    wire           sig_in    = hit_sig && (rd_index < 10'(SIG_BYTES));
    wire           fuse_in   = hit_fuse && (rd_index[7:0] < 8'(FUSE_BYTES));
    wire           aligned   = (s_axi_araddr[1:0] == 2'h0);
    wire [7:0]     sig_sel   = sig_in ? sig_bytes[rd_index[5:0]] : 8'h00;
    wire [7:0]     fuse_sel  = fuse_in ? fuse_r[rd_index[3:0]] : 8'h00;
    logic [7:0]    rd_byte;
    logic [1:0]    rd_resp;

    // Holes and offsets past a row's end in its 1 KiB window read zero with OKAY; other addresses but the watchdog register are errors
    always_comb begin
        rd_byte = 8'h00;
        rd_resp = RESP_SLVERR;
        if (!aligned) begin
            rd_resp = RESP_SLVERR;
        end else if (hit_wdt) begin
            rd_byte = wdt_ctrl_r;
            rd_resp = RESP_OKAY;
        end else if (hit_sig) begin
            rd_byte = sig_sel; // [RULE11]
            rd_resp = RESP_OKAY;
        end else if (hit_fuse) begin
            rd_byte = fuse_sel; // [RULE11]
            rd_resp = RESP_OKAY;
        end
    end

    always_comb begin
        rd_state_nxt = rd_state_r;
        rd_nxt       = rd_r;
        case (rd_state_r)
            SFR_RD_IDLE: begin
                if (ar_take) begin
                    rd_nxt.data  = {24'h000000, rd_byte};
                    rd_nxt.resp  = rd_resp;
                    rd_nxt.valid = 1'b1;
                    rd_state_nxt = SFR_RD_RESP;
                end
            end
            SFR_RD_RESP: begin
                if (s_axi_rready) begin
                    rd_nxt.valid = 1'b0;
                    rd_state_nxt = SFR_RD_IDLE;
                end
            end
            default: begin
                rd_state_nxt = SFR_RD_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock) begin
        if (!nrst) begin
            rd_state_r <= SFR_RD_IDLE;
            rd_r       <= '{data: DATA_ZERO, resp: RESP_OKAY, valid: 1'b0};
        end else begin
            rd_state_r <= rd_state_nxt;
            rd_r       <= rd_nxt;
        end
    end

    assign s_axi_arready = (rd_state_r == SFR_RD_IDLE);
    assign s_axi_rdata   = rd_r.data;
    assign s_axi_rresp   = rd_r.resp;
    assign s_axi_rvalid  = rd_r.valid;

    // ------------------------------------------------------------
    // Write channel
    // ------------------------------------------------------------
    // Every location is read-only: writes complete with OKAY and change nothing
    sfr_wr_state_t wr_state_r;
    sfr_wr_state_t wr_state_nxt;
    logic          aw_seen_r;
    logic          aw_seen_nxt;
    logic          w_seen_r;
    logic          w_seen_nxt;
    wire           aw_take = s_axi_awvalid && s_axi_awready;
    wire           w_take  = s_axi_wvalid && s_axi_wready;
    wire           aw_have = aw_seen_r || aw_take;
    wire           w_have  = w_seen_r || w_take;

    always_comb begin
        wr_state_nxt = wr_state_r;
        aw_seen_nxt  = aw_seen_r;
        w_seen_nxt   = w_seen_r;
        case (wr_state_r)
            SFR_WR_IDLE, SFR_WR_HALF: begin
                if (aw_have && w_have) begin
                    aw_seen_nxt  = 1'b0;
                    w_seen_nxt   = 1'b0;
                    wr_state_nxt = SFR_WR_RESP; // [RULE11]
                end else if (aw_have || w_have) begin
                    aw_seen_nxt  = aw_have;
                    w_seen_nxt   = w_have;
                    wr_state_nxt = SFR_WR_HALF;
                end
            end
            SFR_WR_RESP: begin
                if (s_axi_bready) begin
                    wr_state_nxt = SFR_WR_IDLE;
                end
            end
            default: begin
                wr_state_nxt = SFR_WR_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock) begin
        if (!nrst) begin
            wr_state_r <= SFR_WR_IDLE;
            aw_seen_r  <= 1'b0;
            w_seen_r   <= 1'b0;
        end else begin
            wr_state_r <= wr_state_nxt;
            aw_seen_r  <= aw_seen_nxt;
            w_seen_r   <= w_seen_nxt;
        end
    end

    assign s_axi_awready = (wr_state_r != SFR_WR_RESP) && !aw_seen_r;
    assign s_axi_wready  = (wr_state_r != SFR_WR_RESP) && !w_seen_r;
    assign s_axi_bvalid  = (wr_state_r == SFR_WR_RESP);
    assign s_axi_bresp   = RESP_OKAY;

endmodule : sfr_rows

`default_nettype wire

// >>> verif/sfr_rows_asserts.sv
/* Concurrent checks on the bus ports and the watchdog copy of sfr_rows.
   Assumes it is bound to sfr_rows and that nrst is synchronous to clock. */
`timescale 1ns/100ps
`default_nettype none
module sfr_rows_asserts
    import sfr_pkg::*;
(
    input wire logic                        clock,
    input wire logic                        nrst,
    input wire logic [87:0]                 fuse_row_nv,
    input wire logic                        s_axi_awvalid,
    input wire logic                        s_axi_awready,
    input wire logic                        s_axi_wvalid,
    input wire logic                        s_axi_wready,
    input wire logic [1:0]                  s_axi_bresp,
    input wire logic                        s_axi_bvalid,
    input wire logic                        s_axi_bready,
    input wire logic [sfr_pkg::ADDR_W-1:0]  s_axi_araddr,
    input wire logic                        s_axi_arvalid,
    input wire logic                        s_axi_arready,
    input wire logic [31:0]                 s_axi_rdata,
    input wire logic [1:0]                  s_axi_rresp,
    input wire logic                        s_axi_rvalid,
    input wire logic                        s_axi_rready,
    input wire logic [7:0]                  watchdog_control_first
);
    default clocking @(posedge clock); endclocking
    default disable iff (!nrst);
    wire logic rd_take = s_axi_arvalid && s_axi_arready;
    rd_answer_a: assert property (rd_take |=> s_axi_rvalid)
        else $error("read not answered one cycle after address");
    rd_hold_a: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped before rready");
    ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read address taken while a read is outstanding");
    rd_error_a: assert property (rd_take
        && (s_axi_araddr[1:0] != 2'h0 || s_axi_araddr > WDT_CTRL_ADDR)
        |=> s_axi_rresp == RESP_SLVERR && s_axi_rdata == DATA_ZERO)
        else $error("bad address not answered with error and zero");
    rd_wdt_a: assert property (rd_take && s_axi_araddr == WDT_CTRL_ADDR
        |=> s_axi_rdata == {24'h0, watchdog_control_first})
        else $error("watchdog register read differs from its port");
    wr_answer_a: assert property (s_axi_awvalid && s_axi_awready
        && s_axi_wvalid && s_axi_wready
        |=> s_axi_bvalid && s_axi_bresp == RESP_OKAY)
        else $error("write not answered okay one cycle after both channels");
    wdt_window_a: assert property ($rose(nrst)
        |-> watchdog_control_first[WINDOW_MSB:WINDOW_LSB]
            == $past(fuse_row_nv[WINDOW_MSB:WINDOW_LSB]))
        else $error("window field not copied from fuse during reset");
    wdt_period_a: assert property ($rose(nrst)
        |-> watchdog_control_first[PERIOD_MSB:PERIOD_LSB]
            == $past(fuse_row_nv[PERIOD_MSB:PERIOD_LSB]))
        else $error("period field not copied from fuse during reset");
    wdt_stable_a: assert property ($past(nrst) |-> $stable(watchdog_control_first))
        else $error("watchdog register changed outside reset");
    cover property (rd_take && s_axi_araddr == WDT_CTRL_ADDR);
    cover property (s_axi_rvalid && !s_axi_rready);
    cover property (s_axi_bvalid && s_axi_bready);
endmodule : sfr_rows_asserts
bind sfr_rows sfr_rows_asserts i_sfr_rows_asserts (.clock(clock), .nrst(nrst),
    .fuse_row_nv(fuse_row_nv), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .watchdog_control_first(watchdog_control_first));
`default_nettype wire

// >>> verif/tb.sv
/* Self-checking bench for sfr_rows over AXI4-Lite.
   Assumes the package and the bound checker are compiled first. */
`timescale 1ns/100ps
`default_nettype none
module tb;
    import sfr_pkg::*;
    logic clock, nrst, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [11:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, d;
    logic [1:0]  s_axi_bresp, s_axi_rresp, r;
    logic [3:0]  s_axi_wstrb;
    logic [151:0] sig_v;
    logic [87:0] fuse_row_nv, fuse_snap;
    logic [23:0] identity_code;
    logic [79:0] unique_id;
    logic [15:0] temp_correction;
    logic [7:0]  ol3, ol5, oh3, oh5, watchdog_control_first;
    int err_count, comparisons;
    assign {oh5, oh3, ol5, ol3, temp_correction, unique_id, identity_code} = sig_v;
    sfr_rows i_sfr_rows (.clock(clock), .nrst(nrst), .identity_code(identity_code),
        .unique_id(unique_id), .temp_correction(temp_correction), .osc_low_freq_error_3v(ol3),
        .osc_low_freq_error_5v(ol5), .osc_high_freq_error_3v(oh3), .osc_high_freq_error_5v(oh5),
        .fuse_row_nv(fuse_row_nv), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
        .watchdog_control_first(watchdog_control_first));
    // ----------------------------------------
    // Bus tasks
    // ----------------------------------------
    task automatic check(input logic [33:0] seen, input logic [33:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_count++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    // A stall holds rready low so the slave must keep its answer standing
    task automatic axi_read(input logic [11:0] a, input int stall);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= (stall == 0);
        do @(posedge clock); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        repeat (stall) @(posedge clock);
        s_axi_rready <= 1'b1;
        do @(posedge clock); while (s_axi_rvalid !== 1'b1);
        d = s_axi_rdata;
        r = s_axi_rresp;
    endtask : axi_read
    task automatic axi_write(input logic [11:0] a, input logic [31:0] v);
        logic aw_ok, w_ok;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!(aw_ok && w_ok)) begin
            @(posedge clock);
            if (s_axi_awready === 1'b1) aw_ok = 1'b1;
            if (s_axi_wready === 1'b1) w_ok = 1'b1;
            if (aw_ok) s_axi_awvalid <= 1'b0;
            if (w_ok) s_axi_wvalid <= 1'b0;
        end
        do @(posedge clock); while (s_axi_bvalid !== 1'b1);
        check({s_axi_bresp, 32'h0}, {RESP_OKAY, 32'h0});
    endtask : axi_write
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic do_reset(input logic [87:0] f);
        fuse_row_nv <= f;
        nrst <= 1'b0;
        repeat (10) @(posedge clock);
        nrst <= 1'b1;
        fuse_snap = f;
        @(posedge clock);
    endtask : do_reset
    task automatic test_sig(input logic [7:0] p);
        logic [151:0] v;
        logic [31:0] e;
        for (int i = 0; i < 19; i++) v[8*i+:8] = p + 8'(i * 37);
        sig_v <= v;
        @(posedge clock);
        for (int i = 0; i < 40; i++) begin
            e = (i < 13) ? {24'h0, v[8*i+:8]} : 32'h0;
            if (i >= 32 && i < 38) e = {24'h0, v[8*(i-19)+:8]};
            axi_read(12'(4 * i), i % 3);
            if (i < 32) check({r, d}, {RESP_OKAY, e});
            else check({r, d}, {RESP_OKAY, e});
        end
        $display("test_sig done");
    endtask : test_sig
    task automatic test_fuse;
        logic [31:0] e;
        for (int i = 0; i < 11; i++) begin
            e = (i == FUSE_RSV_A_IDX || i == FUSE_RSV_B_IDX) ? 32'h0 : {24'h0, fuse_snap[8*i+:8]};
            axi_read(FUSE_BASE + 12'(4 * i), 0);
            check({r, d}, {RESP_OKAY, e});
        end
        axi_read(WDT_CTRL_ADDR, 1);
        check({r, d}, {RESP_OKAY, 24'h0, fuse_snap[7:0]});
        check({26'h0, watchdog_control_first}, {26'h0, fuse_snap[7:0]});
        $display("test_fuse done");
    endtask : test_fuse
    task automatic test_write_and_errors;
        logic [11:0] a [3] = '{12'h000, 12'h400, 12'h800};
        foreach (a[k]) axi_write(a[k], ~{24'h0, fuse_snap[7:0]});
        foreach (a[k]) begin
            axi_read(a[k], 0);
            check({r, d}, {RESP_OKAY, 24'h0,
                (k == 0) ? sig_v[7:0] : fuse_snap[7:0]});
        end
        axi_read(12'hC00, 0);
        check({r, d}, {RESP_SLVERR, DATA_ZERO});
        axi_read(12'h001, 2);
        check({r, d}, {RESP_SLVERR, DATA_ZERO});
        $display("test_write_and_errors done");
    endtask : test_write_and_errors
    // A fuse change must stay hidden until the next reset
    task automatic test_fuse_reload;
        fuse_row_nv <= ~fuse_snap;
        @(posedge clock);
        test_fuse();
        do_reset(~fuse_snap);
        test_fuse();
        $display("test_fuse_reload done");
    endtask : test_fuse_reload
    task automatic tally_and_finish;
        $display("Comparisons %0d, mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : tally_and_finish
    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end
    initial begin
        repeat (6000) @(posedge clock);
        err_count++;
        tally_and_finish();
    end
    initial begin
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, sig_v} = '0;
        s_axi_wstrb = 4'hF;
        err_count = 0;
        comparisons = 0;
        do_reset(88'h0A_0B_0C_0D_0E_0F_10_11_12_13_5C);
        test_fuse();
        test_sig(8'hA5);
        test_sig(8'h3C);
        test_write_and_errors();
        test_fuse_reload();
        tally_and_finish();
    end
endmodule : tb
`default_nettype wire
